// >>> src/two_level_interrupt_controller.v
`timescale 1ns/1ns
`default_nettype none
`include "irq_defs.vh"

module two_level_interrupt_controller (
  // Clock and reset.
  input  wire        clk,
  input  wire        sys_rst,
  // Special function register port.
  input  wire [7:0]  sfr_addr,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  output reg         sfr_hit,
  // Peripheral request levels, same clock domain.
  input  wire        supply_monitor_request,
  input  wire        watchdog_request,
  input  wire        ext0_request,
  input  wire        converter_ready_request,
  input  wire        timer0_request,
  input  wire        ext1_request,
  input  wire        timer1_request,
  input  wire        serial_port_request,
  input  wire        uart_request,
  input  wire        timer2_request,
  input  wire        interval_counter_request,
  // Processor core side.
  output reg         irq_request,
  output reg  [15:0] irq_vector,
  output reg         irq_high_level,
  output reg  [3:0]  irq_source,
  input  wire        irq_ack,
  input  wire        irq_return,
  output reg  [10:0] irq_taken,
  output wire        in_high_service,
  output wire        in_low_service
);

  // Register storage.
  reg  [7:0]  interrupt_enable_main_reg;
  reg  [7:0]  secondary_irq_enable_level_reg;
  reg  [7:0]  interrupt_level_select_reg;
  reg         high_active_reg;
  reg         low_active_reg;

  // Per-source views in polling order.
  reg  [10:0] src_request;
  reg  [10:0] src_enable;
  reg  [10:0] src_level;
  wire [10:0] src_pending;
  wire [10:0] high_pending;
  wire [10:0] low_pending;
  wire        global_irq_gate;
  wire        pick_high;
  wire        pick_low;
  wire [3:0]  pick_index;
  wire        request_next;

  // Mnemonic views of the enable and level bits.
  wire converter_irq_enable        = interrupt_enable_main_reg[`BIT_CONVERTER];
  wire timer2_irq_enable           = interrupt_enable_main_reg[`BIT_TIMER2];
  wire uart_irq_enable             = interrupt_enable_main_reg[`BIT_UART];
  wire timer1_irq_enable           = interrupt_enable_main_reg[`BIT_TIMER1];
  wire ext1_irq_enable             = interrupt_enable_main_reg[`BIT_EXT1];
  wire timer0_irq_enable           = interrupt_enable_main_reg[`BIT_TIMER0];
  wire ext0_irq_enable             = interrupt_enable_main_reg[`BIT_EXT0];
  wire converter_irq_level         = interrupt_level_select_reg[`BIT_CONVERTER];
  wire timer2_irq_level            = interrupt_level_select_reg[`BIT_TIMER2];
  wire uart_irq_level              = interrupt_level_select_reg[`BIT_UART];
  wire timer1_irq_level            = interrupt_level_select_reg[`BIT_TIMER1];
  wire ext1_irq_level              = interrupt_level_select_reg[`BIT_EXT1];
  wire timer0_irq_level            = interrupt_level_select_reg[`BIT_TIMER0];
  wire ext0_irq_level              = interrupt_level_select_reg[`BIT_EXT0];
  wire interval_counter_irq_level  =
    secondary_irq_enable_level_reg[`BIT_INTERVAL_COUNTER_LEVEL];
  wire supply_monitor_irq_level    =
    secondary_irq_enable_level_reg[`BIT_SUPPLY_MONITOR_LEVEL];
  wire serial_irq_level            =
    secondary_irq_enable_level_reg[`BIT_SERIAL_LEVEL];
  wire interval_counter_irq_enable =
    secondary_irq_enable_level_reg[`BIT_INTERVAL_COUNTER_ENABLE];
  wire supply_monitor_irq_enable   =
    secondary_irq_enable_level_reg[`BIT_SUPPLY_MONITOR_ENABLE];
  wire serial_irq_enable           =
    secondary_irq_enable_level_reg[`BIT_SERIAL_ENABLE];

  // Returns the index of the lowest set bit, which is the first one polled.
  function [3:0] first_set;
    input [10:0] vec;
    integer i;
    begin
      first_set = 4'd0;
      for (i = `SRC_COUNT - 1; i >= 0; i = i - 1) begin
        if (vec[i]) begin
          first_set = i[3:0];
        end
      end
    end
  endfunction

  // Maps a source index to its fixed vector address.
  function [15:0] vector_of;
    input [3:0] idx;
    begin
      case (idx)
        `SRC_SUPPLY_MONITOR:   vector_of = `VEC_SUPPLY_MONITOR;
        `SRC_WATCHDOG:         vector_of = `VEC_WATCHDOG;
        `SRC_EXT0:             vector_of = `VEC_EXT0;
        `SRC_CONVERTER:        vector_of = `VEC_CONVERTER;
        `SRC_TIMER0:           vector_of = `VEC_TIMER0;
        `SRC_EXT1:             vector_of = `VEC_EXT1;
        `SRC_TIMER1:           vector_of = `VEC_TIMER1;
        `SRC_SERIAL:           vector_of = `VEC_SERIAL;
        `SRC_UART:             vector_of = `VEC_UART;
        `SRC_TIMER2:           vector_of = `VEC_TIMER2;
        `SRC_INTERVAL_COUNTER: vector_of = `VEC_INTERVAL_COUNTER;
        default:               vector_of = `VEC_EXT0;
      endcase
    end
  endfunction

  // Gathers requests, enables and levels into polling order.
  always @* begin
    src_request = {interval_counter_request, timer2_request, uart_request,
                   serial_port_request, timer1_request, ext1_request,
                   timer0_request, converter_ready_request, ext0_request,
                   watchdog_request, supply_monitor_request};
    src_enable  = {interval_counter_irq_enable, timer2_irq_enable,
                   uart_irq_enable, serial_irq_enable, timer1_irq_enable,
                   ext1_irq_enable, timer0_irq_enable, converter_irq_enable,
                   ext0_irq_enable, 1'b1, supply_monitor_irq_enable};
    src_level   = {interval_counter_irq_level, timer2_irq_level,
                   uart_irq_level, serial_irq_level, timer1_irq_level,
                   ext1_irq_level, timer0_irq_level, converter_irq_level,
                   ext0_irq_level, ext0_irq_level, supply_monitor_irq_level};
  end

  // A source counts only while its own enable (the watchdog has none) and the global gate are set.
  assign global_irq_gate = interrupt_enable_main_reg[`BIT_GLOBAL_IRQ_GATE];
  assign src_pending  = src_request & src_enable & {11{global_irq_gate}};
  assign high_pending = src_pending & src_level;
  assign low_pending  = src_pending & ~src_level;

  // High requests win over low ones and may pre-empt a low routine.
  assign pick_high = (|high_pending) & ~high_active_reg;
  // Low requests wait while any routine is running.
  assign pick_low  = ~pick_high & (|low_pending) & ~high_active_reg
                     & ~low_active_reg;
  assign pick_index = pick_high ? first_set(high_pending)
                                : first_set(low_pending);
  // The offer is withdrawn in the cycle after an acknowledge.
  assign request_next = (pick_high | pick_low) & ~irq_ack;

  // Register writes; unimplemented bits hold their reset value.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_enable_main_reg      <= `RST_INTERRUPT_ENABLE_MAIN;
      secondary_irq_enable_level_reg <= `RST_SECONDARY_IRQ_ENABLE_LEVEL;
      interrupt_level_select_reg     <= `RST_INTERRUPT_LEVEL_SELECT;
    end else if (sfr_wr) begin
      case (sfr_addr)
        `ADDR_INTERRUPT_ENABLE_MAIN: begin
          interrupt_enable_main_reg <= sfr_wdata & `MASK_INTERRUPT_ENABLE_MAIN;
        end
        `ADDR_SECONDARY_IRQ_ENABLE_LEVEL: begin
          // Bit 3 is stored as written; software keeps it zero.
          secondary_irq_enable_level_reg <=
            (sfr_wdata & `MASK_SECONDARY_IRQ_ENABLE_LEVEL) |
            (`RST_SECONDARY_IRQ_ENABLE_LEVEL & ~`MASK_SECONDARY_IRQ_ENABLE_LEVEL);
        end
        `ADDR_INTERRUPT_LEVEL_SELECT: begin
          interrupt_level_select_reg <= sfr_wdata & `MASK_INTERRUPT_LEVEL_SELECT;
        end
        default: begin
          interrupt_enable_main_reg <= interrupt_enable_main_reg;
        end
      endcase
    end
  end

  // Registered read data, valid the cycle after the read strobe.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `ADDR_INTERRUPT_ENABLE_MAIN: begin
          sfr_rdata <= interrupt_enable_main_reg;
          sfr_hit   <= 1'b1;
        end
        `ADDR_SECONDARY_IRQ_ENABLE_LEVEL: begin
          sfr_rdata <= secondary_irq_enable_level_reg;
          sfr_hit   <= 1'b1;
        end
        `ADDR_INTERRUPT_LEVEL_SELECT: begin
          sfr_rdata <= interrupt_level_select_reg;
          sfr_hit   <= 1'b1;
        end
        default: begin
          sfr_rdata <= 8'h00;
          sfr_hit   <= 1'b0;
        end
      endcase
    end else begin
      sfr_hit <= 1'b0;
    end
  end

  // Offer to the core: request, vector, level and source, from flip-flops.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_request    <= 1'b0;
      irq_vector     <= 16'h0000;
      irq_high_level <= 1'b0;
      irq_source     <= 4'h0;
    end else begin
      irq_request <= request_next;
      if (request_next) begin
        irq_vector     <= vector_of(pick_index);
        irq_high_level <= pick_high;
        irq_source     <= pick_index;
      end
    end
  end

  // Service level tracking: acknowledge enters a level, return leaves the innermost.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_active_reg <= 1'b0;
      low_active_reg  <= 1'b0;
      irq_taken       <= 11'h000;
    end else begin
      irq_taken <= 11'h000;
      if (irq_ack && irq_request) begin
        irq_taken <= 11'h001 << irq_source;
        if (irq_high_level) begin
          high_active_reg <= 1'b1;
        end else begin
          low_active_reg <= 1'b1;
        end
      end else if (irq_return) begin
        if (high_active_reg) begin
          high_active_reg <= 1'b0;
        end else begin
          low_active_reg <= 1'b0;
        end
      end
    end
  end

  // Service state visible to the core.
  assign in_high_service = high_active_reg;
  assign in_low_service  = low_active_reg;

endmodule // two_level_interrupt_controller
`default_nettype wire

// >>> src/irq_defs.vh
`ifndef IRQ_DEFS_VH
`define IRQ_DEFS_VH

// Special function register addresses of the interrupt block.
`define ADDR_INTERRUPT_ENABLE_MAIN      8'ha8
`define ADDR_SECONDARY_IRQ_ENABLE_LEVEL 8'ha9
`define ADDR_INTERRUPT_LEVEL_SELECT     8'hb8

// Reset values.
`define RST_INTERRUPT_ENABLE_MAIN      8'h00
`define RST_SECONDARY_IRQ_ENABLE_LEVEL 8'ha0
`define RST_INTERRUPT_LEVEL_SELECT     8'h00

// Writable bits; unimplemented bits keep their reset value.
`define MASK_INTERRUPT_ENABLE_MAIN      8'hff
`define MASK_SECONDARY_IRQ_ENABLE_LEVEL 8'h7f
`define MASK_INTERRUPT_LEVEL_SELECT     8'h7f

// Main enable and level select bit positions (shared layout).
`define BIT_GLOBAL_IRQ_GATE 7
`define BIT_CONVERTER       6
`define BIT_TIMER2          5
`define BIT_UART            4
`define BIT_TIMER1          3
`define BIT_EXT1            2
`define BIT_TIMER0          1
`define BIT_EXT0            0

// Secondary register bit positions.
`define BIT_INTERVAL_COUNTER_LEVEL  6
`define BIT_SUPPLY_MONITOR_LEVEL    5
`define BIT_SERIAL_LEVEL            4
`define BIT_INTERVAL_COUNTER_ENABLE 2
`define BIT_SUPPLY_MONITOR_ENABLE   1
`define BIT_SERIAL_ENABLE           0

// Source indices in polling order, index 0 polled first.
`define SRC_SUPPLY_MONITOR   4'd0
`define SRC_WATCHDOG         4'd1
`define SRC_EXT0             4'd2
`define SRC_CONVERTER        4'd3
`define SRC_TIMER0           4'd4
`define SRC_EXT1             4'd5
`define SRC_TIMER1           4'd6
`define SRC_SERIAL           4'd7
`define SRC_UART             4'd8
`define SRC_TIMER2           4'd9
`define SRC_INTERVAL_COUNTER 4'd10
`define SRC_COUNT            11

// Vector addresses.
`define VEC_EXT0             16'h0003
`define VEC_TIMER0           16'h000b
`define VEC_EXT1             16'h0013
`define VEC_TIMER1           16'h001b
`define VEC_UART             16'h0023
`define VEC_TIMER2           16'h002b
`define VEC_CONVERTER        16'h0033
`define VEC_SERIAL           16'h003b
`define VEC_SUPPLY_MONITOR   16'h0043
`define VEC_INTERVAL_COUNTER 16'h0053
`define VEC_WATCHDOG         16'h005b

`endif

// >>> test/irq_chk.sv
`timescale 1ns/1ns
`default_nettype none
module irq_chk (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port.
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  // Core side.
  input wire logic        irq_request,
  input wire logic        irq_high_level,
  input wire logic [3:0]  irq_source,
  input wire logic        irq_ack,
  input wire logic        irq_return,
  input wire logic [10:0] irq_taken,
  input wire logic        in_high_service,
  input wire logic        in_low_service
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Mirror of the global gate bit, followed from register writes.
  logic gate_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      gate_reg <= 1'b0;
    else if (sfr_wr && sfr_addr == 8'ha8)
      gate_reg <= sfr_wdata[7];
  end
  gate_blocks_all_a: assert property (!gate_reg && !$past(gate_reg) |-> !irq_request)
    else $error("request offered with global gate off");
  no_high_nest_a: assert property (in_high_service |-> !(irq_request && irq_high_level))
    else $error("high request offered during high routine");
  busy_only_high_a: assert property (irq_request &&
    (in_low_service || in_high_service) |-> irq_high_level)
    else $error("low request offered during a routine");
  taken_match_a: assert property (irq_ack && irq_request |=>
    irq_taken == (11'h1 << $past(irq_source))) else $error("taken bit mismatch");
  taken_pulse_a: assert property (irq_taken != 11'h0 |=> irq_taken == 11'h0)
    else $error("taken pulse too long");
  high_enter_a: assert property (irq_ack && irq_request && irq_high_level |=>
    in_high_service && !irq_request) else $error("high routine not entered");
  return_pop_a: assert property (irq_return && !irq_ack && in_high_service |=>
    !in_high_service && in_low_service == $past(in_low_service)) else $error("bad return");
  level_bit7_a: assert property (sfr_rd && sfr_addr == 8'hb8 |=> sfr_hit && !sfr_rdata[7])
    else $error("level select bit 7 not zero");
  // Main scenarios reached.
  cover property (in_low_service && irq_request && irq_high_level);
  cover property (irq_taken != 11'h0);
  cover property (irq_return && in_high_service);
endmodule // irq_chk
bind two_level_interrupt_controller irq_chk i_irq_chk (.*);
`default_nettype wire

// >>> test/core_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_model (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       sys_rst,
  // Controller side.
  input wire logic       irq_request,
  output var logic       irq_ack,
  output var logic       irq_return,
  // Bench control: ack delay and return command.
  input wire logic [1:0] wait_n,
  input wire logic       ret_go
);
  logic [1:0] cnt_reg;
  // Acks an offer after wait_n cycles; return follows the bench command.
  always @(posedge clk) begin
    if (sys_rst) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      cnt_reg <= 2'd0;
    end else begin
      irq_return <= ret_go;
      irq_ack <= irq_request && !irq_ack && cnt_reg == wait_n;
      cnt_reg <= (irq_request && cnt_reg != wait_n) ? cnt_reg + 2'd1 : 2'd0;
    end
  end
endmodule // core_model
`default_nettype wire

// >>> test/tb_two_level_interrupt_controller.sv
`timescale 1ns/1ns
`default_nettype none
module tb_two_level_interrupt_controller;
  logic clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, ret_go = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0;
  logic [10:0] req = 0;
  logic [1:0] wait_n = 0;
  int errors = 0, comparisons = 0;
  wire [7:0] sfr_rdata;
  wire [15:0] irq_vector;
  wire [10:0] irq_taken;
  wire [3:0] irq_source;
  wire sfr_hit, irq_request, irq_high_level, irq_ack, irq_return, in_hi, in_lo;
  logic [15:0] vec [11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
                            16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
  logic [15:0] en [11] = '{16'h0280, 16'h0080, 16'h0081, 16'h00c0, 16'h0082, 16'h0084,
                           16'h0088, 16'h0180, 16'h0090, 16'h00a0, 16'h0480};
  always #25 clk = ~clk;
  two_level_interrupt_controller i_two_level_interrupt_controller (
    .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .supply_monitor_request(req[0]), .watchdog_request(req[1]), .ext0_request(req[2]),
    .converter_ready_request(req[3]), .timer0_request(req[4]), .ext1_request(req[5]),
    .timer1_request(req[6]), .serial_port_request(req[7]), .uart_request(req[8]),
    .timer2_request(req[9]), .interval_counter_request(req[10]),
    .irq_request(irq_request), .irq_vector(irq_vector), .irq_high_level(irq_high_level),
    .irq_source(irq_source), .irq_ack(irq_ack), .irq_return(irq_return),
    .irq_taken(irq_taken), .in_high_service(in_hi), .in_low_service(in_lo));
  core_model i_core_model (.clk(clk), .sys_rst(sys_rst), .irq_request(irq_request),
    .irq_ack(irq_ack), .irq_return(irq_return), .wait_n(wait_n), .ret_go(ret_go));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(negedge clk);
    sfr_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    {sfr_addr, sfr_rd} = {a, 1'b1};
    @(negedge clk);
    sfr_rd = 0;
    chk("rdata", {8'h00, e}, {8'h00, sfr_rdata});
    chk("hit", {15'h0, a == 8'ha8 || a == 8'ha9 || a == 8'hb8}, {15'h0, sfr_hit});
  endtask
  // Waits for an offer, then checks who is offered.
  task automatic offer(input int s, input logic h);
    for (int k = 0; k < 20 && irq_request !== 1'b1; k++) @(negedge clk);
    chk("offer", 16'h1, {15'h0, irq_request});
    chk("source", 16'(s), {12'h000, irq_source});
    chk("level", {15'h0, h}, {15'h0, irq_high_level});
    chk("vector", vec[s], irq_vector);
  endtask
  task automatic take(input int s);
    for (int k = 0; k < 20 && irq_taken === 11'h0; k++) @(negedge clk);
    chk("taken", 16'(11'h1 << s), {5'h00, irq_taken});
  endtask
  task automatic idle;
    repeat (3) @(negedge clk);
    chk("request", 16'h0, {15'h0, irq_request});
  endtask
  task automatic ret;
    @(negedge clk) ret_go = 1;
    @(negedge clk) ret_go = 0;
    repeat (2) @(negedge clk);
  endtask
  task automatic close_out;
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles of the sequence.
  initial begin
    #500000;
    errors++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) sys_rst = 0;
    rd(8'ha8, 8'h00);
    rd(8'ha9, 8'ha0);
    rd(8'hb8, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'hb8, 8'hff);
    rd(8'hb8, 8'h7f);
    wr(8'ha9, 8'h77);
    rd(8'ha9, 8'hf7);
    wr(8'hb8, 8'h00);
    wr(8'ha9, 8'h07);
    wr(8'ha8, 8'h7f);
    req = 11'h7ff;
    idle;
    // Drop all requests so that no source is served while the enables change.
    req = 0;
    for (int i = 0; i < 11; i++) begin
      wr(8'ha8, en[i][7:0]);
      wr(8'ha9, en[i][15:8]);
      req = 11'h7fd | (11'h1 << i);
      offer(i, 0);
      take(i);
      idle;
      req = 0;
      ret;
      chk("low busy", 16'h0, {15'h0, in_lo});
    end
    wait_n = 2'd3;
    wr(8'ha8, 8'hff);
    wr(8'ha9, 8'h07);
    req = 11'h7ff;
    for (int i = 0; i < 11; i++) begin
      offer(i, 0);
      take(i);
      req[i] = 0;
      ret;
    end
    wait_n = 2'd0;
    wr(8'hb8, 8'h20);
    wr(8'ha9, 8'h47);
    req = 11'h7ff;
    offer(9, 1);
    take(9);
    idle;
    req[9] = 0;
    ret;
    offer(10, 1);
    take(10);
    req[10] = 0;
    ret;
    offer(0, 0);
    take(0);
    req[9] = 1;
    offer(9, 1);
    take(9);
    chk("both busy", 16'h3, {14'h0, in_hi, in_lo});
    req = 0;
    ret;
    chk("pop high", 16'h1, {14'h0, in_hi, in_lo});
    ret;
    chk("pop low", 16'h0, {14'h0, in_hi, in_lo});
    // Enter a routine, then reset in mid-service.
    req = 11'h001;
    take(0);
    @(negedge clk) sys_rst = 1;
    @(negedge clk) sys_rst = 0;
    rd(8'ha9, 8'ha0);
    chk("reset idle", 16'h0, {13'h0, in_hi, in_lo, irq_request});
    close_out;
  end
endmodule // tb_two_level_interrupt_controller
`default_nettype wire
